// ==== test/lc_safety_monitor.sv ====
`include "lc_defs.svh"

module lc_safety_monitor #(
  parameter bit FULL_VARIANT = 1'b1,
  parameter int unsigned SETTLE_CYCLES = 8
) (
  // Watched inputs
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_beam_interrupted,
  input wire logic i_sensor_fail,
  input wire logic i_muting_a_closed,
  input wire logic i_muting_b_closed,
  input wire logic i_forced_switch_off_input,
  input wire logic i_lockout_release_closed,
  input wire logic i_ext_lockout_closed,
  input wire logic [`LC_RELAYS-1:0] i_final_switch_fb,
  // Watched outputs
  input wire logic [`LC_RELAYS-1:0] o_final_switch_output,
  input wire logic o_lockout_switch_output
);
  timeunit 1ns;
  timeprecision 1ns;
  wire masked = FULL_VARIANT && i_muting_a_closed && i_muting_b_closed;
  int unsigned diff_r;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Margin of three cycles over the settle time and register stages
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || i_final_switch_fb == o_final_switch_output) begin
      diff_r <= 0;
    end else if (i_ce) begin
      diff_r <= diff_r + 1;
    end
  end
  property p_beam;
    i_ce && i_beam_interrupted && !masked |=> o_final_switch_output == 2'h0;
  endproperty
  a_beam: assert property (p_beam)
    else $error("outputs on during beam break");
  property p_fail;
    i_ce && i_sensor_fail && !masked |=> o_final_switch_output == 2'h0;
  endproperty
  a_fail: assert property (p_fail)
    else $error("outputs on during sensor failure");
  property p_forced;
    FULL_VARIANT && i_ce && i_forced_switch_off_input |=>
      o_final_switch_output == 2'h0;
  endproperty
  a_forced: assert property (p_forced)
    else $error("outputs on while forced off");
  property p_start;
    FULL_VARIANT && $rose(i_reset_n) && !i_lockout_release_closed |=>
      !o_lockout_switch_output;
  endproperty
  a_start: assert property (p_start)
    else $error("lockout output on at start");
  property p_ext;
    i_ce && !i_ext_lockout_closed |=> !o_lockout_switch_output;
  endproperty
  a_ext: assert property (p_ext)
    else $error("lockout output on with external lockout open");
  property p_weld;
    diff_r > SETTLE_CYCLES + 4 |-> !o_lockout_switch_output;
  endproperty
  a_weld: assert property (p_weld)
    else $error("lasting feedback disagreement not locked out");
  property p_latch;
    FULL_VARIANT && !o_lockout_switch_output && !i_lockout_release_closed
      |=> !o_lockout_switch_output;
  endproperty
  a_latch: assert property (p_latch)
    else $error("lockout left without release");
  property p_on;
    o_final_switch_output != 2'h0 |->
      o_lockout_switch_output && o_final_switch_output == 2'h3;
  endproperty
  a_on: assert property (p_on)
    else $error("outputs on while locked or split");
endmodule // lc_safety_monitor

bind light_curtain_safety_logic lc_safety_monitor #(
  .FULL_VARIANT(FULL_VARIANT), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_lc_safety_monitor (.i_mclk, .i_reset_n, .i_ce, .i_beam_interrupted,
  .i_sensor_fail, .i_muting_a_closed, .i_muting_b_closed,
  .i_forced_switch_off_input, .i_lockout_release_closed,
  .i_ext_lockout_closed, .i_final_switch_fb, .o_final_switch_output,
  .o_lockout_switch_output);

// ==== test/relay_model.sv ====
module relay_model (
  // Clock
  input wire logic i_mclk,
  // Coil commands and mode
  input wire logic [1:0] i_fso,
  input wire logic i_nc_mode,
  input wire logic [1:0] i_weld,
  // Contact feedback
  output logic [1:0] o_final_fb,
  output logic [1:0] o_prim_fb
);
  timeunit 1ns;
  timeprecision 1ns;
  // A welded contact freezes where it stood, so it sticks once coil drops
  always @(posedge i_mclk) begin
    o_final_fb <= {i_fso[1], i_weld[0] ? o_final_fb[0] : i_fso[0]};
    o_prim_fb[1] <= i_fso[1] ^ i_nc_mode;
    if (!i_weld[1]) begin
      o_prim_fb[0] <= i_fso[0] ^ i_nc_mode;
    end
  end
endmodule // relay_model

// ==== test/tb_light_curtain_safety_logic.sv ====
`include "lc_defs.svh"

module tb_light_curtain_safety_logic;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'h0, i_reset_n = 1'h0, i_ce = 1'h1;
  logic i_beam_interrupted = 1'h0, i_sensor_fail = 1'h0;
  logic i_extraneous_light = 1'h0, i_cable_fault = 1'h0;
  logic i_muting_a_closed = 1'h0, i_muting_b_closed = 1'h0;
  logic i_forced_switch_off_input = 1'h0, i_lockout_release_closed = 1'h0;
  logic i_ext_lockout_closed = 1'h1, i_test_closed = 1'h1;
  logic i_restart_closed = 1'h1, i_primary_machine_relay_nc = 1'h0;
  logic [`LC_ADDR_W-1:0] i_reg_addr = 4'h0;
  logic [`LC_DATA_W-1:0] i_reg_wdata = 8'h00, o_reg_rdata, d, ef;
  logic i_reg_wr = 1'h0, i_reg_rd = 1'h0, nc_mode = 1'h0;
  logic [1:0] i_final_switch_fb, i_primary_machine_relay_fb, weld = 2'h0;
  logic [1:0] o_final_switch_output, s_ffb, s_pfb, s_fso;
  logic o_lockout_switch_output, o_monitor_output, o_emission_enable;
  logic s_lock, s_mon, s_emit, s, off;
  bit lk = 1'b1, slk = 1'b0;
  int seed = 73052, mismatches = 0, checks_done = 0, cyc = 0;
  wire [7:0] got_f = {3'h0, o_lockout_switch_output, o_final_switch_output,
    o_monitor_output, o_emission_enable};
  wire [7:0] got_s = {3'h0, s_lock, s_fso, s_mon, s_emit};

  light_curtain_safety_logic #(.SETTLE_CYCLES(8))
    u_light_curtain_safety_logic (.*);
  light_curtain_safety_logic #(.FULL_VARIANT(1'b0), .SETTLE_CYCLES(8))
    u_light_curtain_safety_logic_s (.*, .i_final_switch_fb(s_ffb),
    .i_primary_machine_relay_fb(s_pfb), .o_reg_rdata(),
    .o_final_switch_output(s_fso), .o_lockout_switch_output(s_lock),
    .o_monitor_output(s_mon), .o_emission_enable(s_emit));
  relay_model u_relay_model (.i_mclk, .i_fso(o_final_switch_output),
    .i_nc_mode(nc_mode), .i_weld(weld), .o_final_fb(i_final_switch_fb),
    .o_prim_fb(i_primary_machine_relay_fb));
  relay_model u_relay_model_s (.i_mclk, .i_fso(s_fso), .i_nc_mode(nc_mode),
    .i_weld(2'h0), .o_final_fb(s_ffb), .o_prim_fb(s_pfb));

  always #50 i_mclk = ~i_mclk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_reg_wr <= 1'h1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_mclk);
    i_reg_wr <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_reg_rd <= 1'h1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'h0;
    #1 d = o_reg_rdata;
    @(posedge i_mclk);
  endtask

  // Reference model of both variants from the latched lockout flags
  task automatic cmp;
    #1;
    s = i_beam_interrupted | i_sensor_fail | i_extraneous_light | i_cable_fault;
    off = i_forced_switch_off_input |
      (!(i_muting_a_closed & i_muting_b_closed) & s);
    ef = {3'h0, !lk, {2{!lk && !off}}, 2'h1};
    chk(got_f, ef);
    ef = {3'h0, !slk, {2{!slk && i_test_closed && i_restart_closed && !s}},
      !slk && i_test_closed && !s, i_test_closed};
    chk(got_s, ef);
    // Hand back on an edge so callers drive inputs there
    @(posedge i_mclk);
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset_n <= 1'h1;
    tick(4);
    cmp;
    i_lockout_release_closed <= 1'h1;
    lk = 1'b0;
    tick(3);
    cmp;
    wr(`LC_CTRL_ADDR, 8'h5a);
    wr(4'h2, 8'hff);
    wr(`LC_STAT_ADDR, 8'h01);
    rd(`LC_CTRL_ADDR);
    chk(d, 8'h5a);
    rd(4'h2);
    chk(d, 8'h00);
    rd(`LC_STAT_ADDR);
    chk(d & 8'hc1, 8'hc0);
    // Muting only ever held for a few cycles at a time
    repeat (40) begin
      {i_beam_interrupted, i_sensor_fail, i_extraneous_light, i_cable_fault,
        i_muting_a_closed, i_muting_b_closed, i_forced_switch_off_input,
        i_test_closed, i_restart_closed} <= 9'($random(seed));
      tick(3);
      cmp;
    end
    {i_beam_interrupted, i_sensor_fail, i_extraneous_light, i_cable_fault,
      i_muting_a_closed, i_muting_b_closed, i_forced_switch_off_input,
      i_test_closed, i_restart_closed} <= 9'h003;
    i_lockout_release_closed <= 1'h0;
    i_ext_lockout_closed <= 1'h0;
    lk = 1'b1;
    slk = 1'b1;
    tick(3);
    cmp;
    rd(`LC_STAT_ADDR);
    chk(d & 8'h21, 8'h21);
    i_ext_lockout_closed <= 1'h1;
    slk = 1'b0;
    tick(3);
    cmp;
    i_lockout_release_closed <= 1'h1;
    lk = 1'b0;
    tick(3);
    cmp;
    i_primary_machine_relay_nc <= 1'h1;
    lk = 1'b1;
    slk = 1'b1;
    tick(3);
    cmp;
    wr(`LC_CTRL_ADDR, 8'h01);
    nc_mode <= 1'h1;
    lk = 1'b0;
    slk = 1'b0;
    tick(20);
    cmp;
    for (int w = 0; w < 2; w++) begin
      weld <= 2'(1 << w);
      i_beam_interrupted <= 1'h1;
      lk = 1'b1;
      tick(20);
      cmp;
      weld <= 2'h0;
      i_beam_interrupted <= 1'h0;
      lk = 1'b0;
      tick(20);
      cmp;
    end
    // Low enable freezes both units in their on state despite a beam break
    i_ce <= 1'h0;
    i_beam_interrupted <= 1'h1;
    tick(3);
    #1;
    chk(got_f, 8'h1d);
    chk(got_s, 8'h1f);
    tick(1);
    i_ce <= 1'h1;
    tick(3);
    cmp;
    // Mid-run reset; control word returns to NO mode, so both lock
    i_lockout_release_closed <= 1'h0;
    i_reset_n <= 1'h0;
    lk = 1'b1;
    slk = 1'b1;
    tick(3);
    i_reset_n <= 1'h1;
    tick(3);
    cmp;
    print_verdict;
  end
endmodule // tb_light_curtain_safety_logic

// ==== verilog/decision_channel.sv ====
`include "lc_defs.svh"

module decision_channel #(
  parameter bit FULL_VARIANT = 1'b1
) (
  // Sensor head
  input wire logic i_beam_interrupted,
  input wire logic i_sensor_fail,
  input wire logic i_extraneous_light,
  input wire logic i_cable_fault,
  // Control contacts
  input wire logic i_muted,
  input wire logic i_forced_off_closed,
  input wire logic i_test_closed,
  // Decisions
  output logic o_switch_off,
  output logic o_monitor_off
);

  function automatic logic sensor_trip(input logic beam, input logic fail,
                                       input logic light, input logic cable);
    sensor_trip = beam | fail | light | cable;
  endfunction

  wire logic head_trip;
  wire logic head_gated;

  assign head_trip = sensor_trip(i_beam_interrupted, i_sensor_fail,
                                 i_extraneous_light, i_cable_fault);
  // Muting hides the whole head report, not just the beams
  assign head_gated = head_trip & ~(FULL_VARIANT & i_muted); // [R1] [R2] [R3] [R4] [R15]

  assign o_switch_off = FULL_VARIANT ?
                        (head_gated | i_forced_off_closed) : // [R5]
                        (head_trip | ~i_test_closed);        // [R6]
  assign o_monitor_off = FULL_VARIANT ? 1'b1 :
                         (sensor_trip(i_beam_interrupted, i_sensor_fail,
                                      i_extraneous_light, i_cable_fault)
                          | ~i_test_closed); // [R13] [R14]

endmodule // decision_channel

// ==== verilog/lc_defs.svh ====
// Functional notes
// R1 - Beam interruption turns both final switch outputs off unless muted (full).
// R2 - Sensor head failure turns both final switch outputs off unless muted (full).
// R3 - Excessive extraneous light turns final switch outputs off unless muted.
// R4 - Broken or shorted cable turns final switch outputs off unless muted.
// R5 - Full variant: closed forced-off input forces outputs off, even muted.
// R6 - Simple variant: open test input turns final switch outputs off.
// R7 - Full variant: lockout output off at start and after power return.
// R8 - Welded final switch relay contact turns lockout output off.
// R9 - Welded primary machine relay contact, seen via feedback, turns lockout off.
// R10 - Disagreeing redundant decision channels turn lockout output off.
// R11 - Open external lockout input turns lockout output off.
// R12 - Observed relay contact type differing from mode setting turns lockout off.
// R13 - Simple variant: monitor output off on any sensor fault or beam break.
// R14 - Simple variant: open test input turns monitor off and stops emission.
// R15 - Full variant: muting makes beam interruptions unable to open outputs.
// R16 - Controller asserts muting only briefly and with care.
// R17 - Full variant: closed lockout release input clears lockout.
// R18 - Full variant: muting active only with both muting inputs closed.
// R19 - Simple variant: open restart input keeps final switch outputs off.
// R20 - Relay feedback disagreeing with final switch state enters lockout.
// R21 - Full variant: lockout latches and holds outputs off until released.
// R22 - Outputs on only with no turn-off condition and no lockout latched.
`ifndef LC_DEFS_SVH
`define LC_DEFS_SVH

// Register port
`define LC_ADDR_W 4
`define LC_DATA_W 8
`define LC_CTRL_ADDR 4'h0
`define LC_STAT_ADDR 4'h4
`define LC_CTRL_RESET 8'h00
`define LC_RDATA_IDLE 8'h00
`define LC_CTRL_NC_BIT 0

// Status fields
`define LC_ST_LOCKED 0
`define LC_ST_MUTED 1
`define LC_ST_CHAN_DIFF 2
`define LC_ST_RELAY_FAULT 3
`define LC_ST_MODE_ERR 4
`define LC_ST_EXT_LOCK 5
`define LC_ST_FSO_LO 6
`define LC_ST_FSO_HI 7

// Relay settle time before feedback disagreement counts
`define LC_SETTLE_MS 20
`define LC_CLK_KHZ 10000
`define LC_CNT_W 20
`define LC_RELAYS 2
`define LC_CHANNELS 2

`endif

// ==== verilog/lc_pkg.sv ====
package lc_pkg;
  typedef enum logic {
    ST_LOCKED,
    ST_RUN
  } lock_state_t;
endpackage

// ==== verilog/light_curtain_safety_logic.sv ====
// Design decisions made here: the placing of the registers and the plain strobed port.
`include "lc_defs.svh"

module light_curtain_safety_logic #(
  parameter bit FULL_VARIANT = 1'b1,
  // Relay settle time in cycles; shorten for simulation
  parameter int unsigned SETTLE_CYCLES = `LC_SETTLE_MS * `LC_CLK_KHZ
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Sensor head reports
  input wire logic i_beam_interrupted,
  input wire logic i_sensor_fail,
  input wire logic i_extraneous_light,
  input wire logic i_cable_fault,
  // Full variant contacts, high when closed
  input wire logic i_muting_a_closed,
  input wire logic i_muting_b_closed,
  input wire logic i_forced_switch_off_input,
  input wire logic i_lockout_release_closed,
  // Common contacts, high when closed
  input wire logic i_ext_lockout_closed,
  // Simple variant contacts, high when closed
  input wire logic i_test_closed,
  input wire logic i_restart_closed,
  // Relay feedback, high when contact closed
  input wire logic [`LC_RELAYS-1:0] i_final_switch_fb,
  input wire logic [`LC_RELAYS-1:0] i_primary_machine_relay_fb,
  input wire logic i_primary_machine_relay_nc,
  // Register port
  input wire logic [`LC_ADDR_W-1:0] i_reg_addr,
  input wire logic [`LC_DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [`LC_DATA_W-1:0] o_reg_rdata,
  // Switching outputs, high when closed
  output logic [`LC_RELAYS-1:0] o_final_switch_output,
  output logic o_lockout_switch_output,
  output logic o_monitor_output,
  output logic o_emission_enable
);

  // Register state
  logic [`LC_DATA_W-1:0] ctrl_r;
  logic [`LC_DATA_W-1:0] rdata_r;
  logic [`LC_DATA_W-1:0] rdata_nxt;

  // Decision state
  lc_pkg::lock_state_t state_r;
  lc_pkg::lock_state_t state_nxt;
  logic [`LC_RELAYS-1:0] fso_r;
  logic [`LC_RELAYS-1:0] fso_nxt;
  logic lockout_r;
  logic lockout_nxt;
  logic monitor_r;
  logic monitor_nxt;
  logic emission_r;
  logic emission_nxt;

  // Channel results and relay checks
  wire logic [`LC_CHANNELS-1:0] chan_off;
  wire logic [`LC_CHANNELS-1:0] chan_mon_off;
  wire logic [`LC_RELAYS-1:0] fsw_weld;
  wire logic [`LC_RELAYS-1:0] pmr_fault;
  wire logic [`LC_RELAYS-1:0] pmr_on;

  // Condition decode
  wire logic muted;
  wire logic forced_off;
  wire logic chan_diff;
  wire logic relay_fault;
  wire logic mode_err;
  wire logic ext_lock;
  wire logic fault;
  wire logic release_req;
  wire logic restart_ok;
  wire logic relay_nc_sel;
  wire logic ctrl_wr;
  wire logic ctrl_rd;
  wire logic stat_rd;
  wire logic [`LC_DATA_W-1:0] status;

  // Both contacts needed; a single stuck contact cannot mute
  assign muted = FULL_VARIANT & i_muting_a_closed
                 & i_muting_b_closed; // [R18]
  assign forced_off = FULL_VARIANT & i_forced_switch_off_input;

  // Two independent decision channels over the same inputs
  genvar c;
  generate
    for (c = 0; c < `LC_CHANNELS; c++) begin : g_chan
      decision_channel #(
        .FULL_VARIANT(FULL_VARIANT)
      ) u_chan (
        .i_beam_interrupted(i_beam_interrupted),
        .i_sensor_fail(i_sensor_fail),
        .i_extraneous_light(i_extraneous_light),
        .i_cable_fault(i_cable_fault),
        .i_muted(muted),
        .i_forced_off_closed(forced_off),
        .i_test_closed(i_test_closed),
        .o_switch_off(chan_off[c]),
        .o_monitor_off(chan_mon_off[c])
      );
    end
  endgenerate

  assign chan_diff = (chan_off != {`LC_CHANNELS{chan_off[0]}})
                     | (chan_mon_off != {`LC_CHANNELS{chan_mon_off[0]}}); // [R10]

  // Relay contact supervision; settle time masks normal switching lag
  assign relay_nc_sel = ctrl_r[`LC_CTRL_NC_BIT];

  genvar k;
  generate
    for (k = 0; k < `LC_RELAYS; k++) begin : g_relay
      // Closed while commanded open means a welded contact
      mismatch_timer #(
        .LIMIT(SETTLE_CYCLES)
      ) u_fsw_chk (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_mismatch(i_final_switch_fb[k] != fso_r[k]), // [R8]
        .o_trip(fsw_weld[k])
      );

      // NC wiring reads inverted, so normalise before comparing
      assign pmr_on[k] = i_primary_machine_relay_fb[k] ^ relay_nc_sel;

      mismatch_timer #(
        .LIMIT(SETTLE_CYCLES)
      ) u_pmr_chk (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_mismatch(pmr_on[k] != fso_r[k]), // [R9] [R20]
        .o_trip(pmr_fault[k])
      );
    end
  endgenerate

  assign relay_fault = (|fsw_weld) | (|pmr_fault);
  assign mode_err = i_primary_machine_relay_nc != relay_nc_sel; // [R12]
  assign ext_lock = ~i_ext_lockout_closed; // [R11]

  // Any lockout cause
  assign fault = relay_fault | chan_diff | mode_err | ext_lock;

  // Release source differs per variant
  assign release_req = FULL_VARIANT ? i_lockout_release_closed // [R17]
                                    : i_restart_closed;
  assign restart_ok = FULL_VARIANT | i_restart_closed; // [R19]

  // Lockout latch; a fault in the release cycle keeps it locked
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lc_pkg::ST_LOCKED: begin
        if (release_req && !fault) begin // [R17] [R21]
          state_nxt = lc_pkg::ST_RUN;
        end
      end
      lc_pkg::ST_RUN: begin
        if (fault) begin // [R21]
          state_nxt = lc_pkg::ST_LOCKED;
        end
      end
      default: begin
        state_nxt = lc_pkg::ST_LOCKED;
      end
    endcase
  end

  // Outputs follow the same-cycle fault, not only the latched state
  assign lockout_nxt = (state_nxt == lc_pkg::ST_RUN) & ~fault; // [R8] [R11]
  assign fso_nxt = {`LC_RELAYS{~chan_off[0] & ~chan_off[1] & lockout_nxt
                               & restart_ok}}; // [R22] [R1] [R6] [R19]
  assign monitor_nxt = ~FULL_VARIANT & ~chan_mon_off[0] & ~chan_mon_off[1]
                       & lockout_nxt; // [R13]
  // Emission only stops in the simple variant
  assign emission_nxt = FULL_VARIANT | i_test_closed; // [R14]

  // Register decode
  assign ctrl_wr = i_reg_wr && (i_reg_addr == `LC_CTRL_ADDR);
  assign ctrl_rd = i_reg_rd && (i_reg_addr == `LC_CTRL_ADDR);
  assign stat_rd = i_reg_rd && (i_reg_addr == `LC_STAT_ADDR);

  assign status = {fso_r[1],
                   fso_r[0],
                   ext_lock,
                   mode_err,
                   relay_fault,
                   chan_diff,
                   muted,
                   state_r == lc_pkg::ST_LOCKED};

  // Unmapped reads and idle cycles return zero
  assign rdata_nxt = ctrl_rd ? ctrl_r :
                     stat_rd ? status : `LC_RDATA_IDLE;

  // Reset lands in lockout for the full variant
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_r <= FULL_VARIANT ? lc_pkg::ST_LOCKED
                              : lc_pkg::ST_RUN; // [R7]
      lockout_r <= 1'b0; // [R7]
      fso_r <= '0;
      monitor_r <= 1'b0;
      emission_r <= 1'b0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      lockout_r <= lockout_nxt;
      fso_r <= fso_nxt;
      monitor_r <= monitor_nxt;
      emission_r <= emission_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ctrl_r <= `LC_CTRL_RESET;
      rdata_r <= `LC_RDATA_IDLE;
    end else if (i_ce) begin
      if (ctrl_wr) begin
        ctrl_r <= i_reg_wdata;
      end
      rdata_r <= rdata_nxt;
    end
  end

  assign o_final_switch_output = fso_r;
  assign o_lockout_switch_output = lockout_r;
  assign o_monitor_output = monitor_r;
  assign o_emission_enable = emission_r;
  assign o_reg_rdata = rdata_r;

endmodule // light_curtain_safety_logic

// ==== verilog/mismatch_timer.sv ====
`include "lc_defs.svh"

module mismatch_timer #(
  parameter int unsigned LIMIT = `LC_SETTLE_MS * `LC_CLK_KHZ
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Disagreement in, persistent fault out
  input wire logic i_mismatch,
  output logic o_trip
);

  logic [`LC_CNT_W-1:0] cnt_r;
  logic [`LC_CNT_W-1:0] cnt_nxt;
  logic trip_r;
  wire logic at_limit;

  assign at_limit = (cnt_r == LIMIT[`LC_CNT_W-1:0]);
  assign cnt_nxt = !i_mismatch ? '0 :
                   at_limit ? cnt_r : cnt_r + `LC_CNT_W'(1);
  assign o_trip = trip_r;

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
      trip_r <= 1'b0;
    end else if (i_ce) begin
      cnt_r <= cnt_nxt;
      trip_r <= i_mismatch & at_limit;
    end
  end

endmodule // mismatch_timer
